// *** src/irsq_pkg.sv ***
// Constants and types shared by the image readout host controller.
package irsq_pkg;
  localparam int LANES = 12;
  localparam int WORD_W = 10;
  localparam int LANE_BUS_W = LANES * WORD_W;
  localparam int SLOT_PIX = 24;
  localparam int SLOT_COUNT = 54;
  localparam int SLOT_W = 6;
  localparam int COL_W = 11;
  localparam int WIN_MAX = 4;
  localparam int WIN_W = 2;
  localparam int LINE_W = 11;
  localparam int TIMER_W = 24;
  localparam int HALF_CNT_W = 7;
  localparam int SYNC_STAGES = 3;
  localparam logic [COL_W-1:0] EVEN_SLOT_TOP = 11'h017;
  localparam logic [LANES-1:0] LANE_FPN_RESET = 12'h000;
  localparam logic CALIB_LINE_ENABLE = 1'b1;
  // Protocol codes on the sync lane.
  localparam logic [WORD_W-1:0] FRAME_BEGIN_CODE = 10'h059;
  localparam logic [WORD_W-1:0] LINE_BEGIN_CODE = 10'h056;
  localparam logic [WORD_W-1:0] FRAME_FINISH_CODE = 10'h05a;
  localparam logic [WORD_W-1:0] LINE_FINISH_CODE = 10'h055;
  localparam logic [WORD_W-1:0] REFERENCE_COLUMNS_CODE = 10'h0a9;
  localparam logic [WORD_W-1:0] CRC_CODE = 10'h0a6;
  localparam logic [WORD_W-1:0] CALIB_CODE = 10'h13c;
  localparam logic [WORD_W-1:0] PIXEL_CODE = 10'h193;
  // Kind of a word handed to the user.
  typedef enum logic [1:0] {
    IRSQ_KIND_PIXEL = 2'h0,
    IRSQ_KIND_CALIB = 2'h1,
    IRSQ_KIND_REF = 2'h2,
    IRSQ_KIND_CRC = 2'h3
  } irsq_kind_t;
  localparam int KIND_W = 2;
  localparam int ENTRY_W = LANE_BUS_W + COL_W + 1 + WIN_W + KIND_W;
  localparam int FIFO_DEPTH = 8;
endpackage : irsq_pkg

// *** src/irsq_fifo.sv ***
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module irsq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys, // System clock.
  input wire logic reset, // Asynchronous reset, active high.
  input wire logic in_valid, // Write request.
  output logic in_ready, // Not full.
  input wire logic [WIDTH-1:0] in_data, // Write data.
  output logic out_valid, // Not empty.
  input wire logic out_ready, // Read accept.
  output logic [WIDTH-1:0] out_data // Head entry.
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] mem_nxt [DEPTH];
  logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    mem_nxt = mem_r;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push) begin
      mem_nxt[wr_r] = in_data;
      wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
    end
    if (pop) begin
      rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
    end
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule : irsq_fifo

// *** src/irsq_host.sv ***
// Host side: exposure pin driver and sync-lane receiver with row remapping.
`timescale 1ns/1ps
module irsq_host
  import irsq_pkg::*;
#(
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  input wire logic clk_sys, // System clock, 100 MHz.
  input wire logic reset, // Asynchronous reset, active high.
  // User control.
  input wire logic slave_mode, // High: host times exposure on the pins.
  input wire logic expose_start, // Pulse: begin one exposure.
  input wire logic [TIMER_W-1:0] exposure_cycles, // Exposure length.
  input wire logic [TIMER_W-1:0] second_stamp_cycles, // Second reset time.
  input wire logic [TIMER_W-1:0] third_stamp_cycles, // Third reset time.
  input wire logic second_stamp_en, // Enable second reset pulse.
  input wire logic third_stamp_en, // Enable third reset pulse.
  input wire logic [WIN_W-1:0] window_count_m1, // Active windows minus 1.
  input wire logic [WIN_MAX*LINE_W-1:0] window_heights, // Lines per window.
  input wire logic [WIN_MAX*SLOT_W-1:0] window_x_start, // First slot, 0-based.
  input wire logic [LANES-1:0] lane_fpn_request, // Wanted correction.
  // Configuration values for the device register loader.
  output logic [LANES-1:0] output_lane_config_fpn, // Bit 1 per data lane.
  output logic sync_lane_config_fpn, // Sync lane correction, kept off.
  output logic sequencer_config_three_calib, // Calibration line enable.
  // Exposure pins.
  output logic exposure_pin, // Exposure level.
  output logic second_reset_pin, // Second slope reset.
  output logic third_reset_pin, // Third slope reset.
  // Link from the device.
  input wire logic link_clk, // Word clock of the lanes.
  input wire logic [WORD_W-1:0] sync_lane, // Protocol code word.
  input wire logic [LANE_BUS_W-1:0] data_lanes, // Twelve data words.
  // Remapped stream to the user.
  output logic pix_valid, // Entry available.
  input wire logic pix_ready, // User takes entry.
  output logic [LANE_BUS_W-1:0] pix_data, // Lane words.
  output logic [COL_W-1:0] pix_col, // Column of lane 0.
  output logic pix_descending, // Lane order runs down the row.
  output logic [WIN_W-1:0] pix_window, // Window of the line.
  output logic [KIND_W-1:0] pix_kind, // Pixel, calib, ref or CRC.
  output logic in_frame, // Between frame begin and finish.
  output logic frame_done, // Pulse at frame finish.
  output logic frame_error, // Sticky: line count mismatch.
  output logic overflow // Sticky: word lost on full FIFO.
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LINE = 3'b010,
    ST_GAP = 3'b100
  } irsq_rx_t;
  typedef enum logic [1:0] {
    EX_IDLE = 2'b01,
    EX_ON = 2'b10
  } irsq_exp_t;

  // Lane column of lane 0 for a 0-based slot and half.
  function automatic logic [COL_W-1:0] col_of(input logic [SLOT_W-1:0] s,
                                              input logic h);
    logic [COL_W-1:0] base;
    base = COL_W'(s) * COL_W'(SLOT_PIX);
    if (!s[0]) col_of = base + COL_W'(h);
    else col_of = base + EVEN_SLOT_TOP - COL_W'(h);
  endfunction : col_of

  // Three-stage synchronisers for the link pins.
  logic [SYNC_STAGES-1:0] lclk_r;
  logic [WORD_W-1:0] sync_s_r [SYNC_STAGES];
  logic [LANE_BUS_W-1:0] data_s_r [SYNC_STAGES];
  logic lclk_lvl_r;
  logic word_tick;
  // A rising edge counts only once the last two stages agree on the high level.
  assign word_tick = lclk_r[1] && lclk_r[2] && !lclk_lvl_r;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      lclk_r <= '0;
      lclk_lvl_r <= 1'b0;
      for (int i = 0; i < SYNC_STAGES; i++) begin
        sync_s_r[i] <= '0;
        data_s_r[i] <= '0;
      end
    end else begin
      lclk_r <= {lclk_r[SYNC_STAGES-2:0], link_clk};
      if (lclk_r[1] == lclk_r[2]) lclk_lvl_r <= lclk_r[2];
      sync_s_r[0] <= sync_lane;
      data_s_r[0] <= data_lanes;
      for (int i = 1; i < SYNC_STAGES; i++) begin
        sync_s_r[i] <= sync_s_r[i-1];
        data_s_r[i] <= data_s_r[i-1];
      end
    end
  end

  // Exposure driver: in slave mode the host owns all three pins.
  irsq_exp_t ex_r, ex_nxt;
  logic [TIMER_W-1:0] ex_cnt_r, ex_cnt_nxt;
  logic exp_pin_r, exp_pin_nxt, ds_pin_r, ds_pin_nxt, ts_pin_r, ts_pin_nxt;
  always_comb begin
    ex_nxt = ex_r;
    ex_cnt_nxt = ex_cnt_r;
    exp_pin_nxt = exp_pin_r;
    ds_pin_nxt = 1'b0;
    ts_pin_nxt = 1'b0;
    case (ex_r)
      EX_IDLE: begin
        if (expose_start && slave_mode && exposure_cycles != '0) begin
          ex_nxt = EX_ON;
          ex_cnt_nxt = '0;
          exp_pin_nxt = 1'b1;
        end
      end
      EX_ON: begin
        ex_cnt_nxt = ex_cnt_r + 1'b1;
        // Each enabled stamp with a count from 1 to one below the exposure length gives a one-cycle reset pulse at its count.
        ds_pin_nxt = second_stamp_en &&
                     (ex_cnt_nxt == second_stamp_cycles);
        ts_pin_nxt = third_stamp_en &&
                     (ex_cnt_nxt == third_stamp_cycles);
        if (ex_cnt_nxt >= exposure_cycles) begin
          ex_nxt = EX_IDLE;
          exp_pin_nxt = 1'b0;
          ds_pin_nxt = 1'b0;
          ts_pin_nxt = 1'b0;
        end
      end
      default: begin
        ex_nxt = EX_IDLE;
        exp_pin_nxt = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ex_r <= EX_IDLE;
      ex_cnt_r <= '0;
      exp_pin_r <= 1'b0;
      ds_pin_r <= 1'b0;
      ts_pin_r <= 1'b0;
    end else begin
      ex_r <= ex_nxt;
      ex_cnt_r <= ex_cnt_nxt;
      exp_pin_r <= exp_pin_nxt;
      ds_pin_r <= ds_pin_nxt;
      ts_pin_r <= ts_pin_nxt;
    end
  end
  assign exposure_pin = exp_pin_r;
  assign second_reset_pin = ds_pin_r;
  assign third_reset_pin = ts_pin_r;

  // Configuration handed to the register loader.
  logic [LANES-1:0] fpn_r;
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) fpn_r <= LANE_FPN_RESET;
    else fpn_r <= lane_fpn_request;
  end
  assign output_lane_config_fpn = fpn_r;
  assign sync_lane_config_fpn = 1'b0;
  assign sequencer_config_three_calib = CALIB_LINE_ENABLE;

  // Receiver: one sync code per word tick classifies the data words.
  irsq_rx_t st_r, st_nxt;
  logic [HALF_CNT_W-1:0] half_r, half_nxt;
  logic [WIN_W-1:0] win_r, win_nxt;
  logic [LINE_W-1:0] line_r, line_nxt;
  logic calib_r, calib_nxt, done_r, done_nxt, err_r, err_nxt;
  logic ovf_r, ovf_nxt;
  logic push;
  logic fifo_ready;
  logic [ENTRY_W-1:0] entry;
  logic [WORD_W-1:0] code;
  logic [KIND_W-1:0] kind;
  logic [SLOT_W-1:0] slot;
  logic [LINE_W-1:0] height;
  assign code = sync_s_r[SYNC_STAGES-1];
  assign height = window_heights[win_r*LINE_W +: LINE_W];
  assign slot = (calib_r ? '0 : window_x_start[win_r*SLOT_W +: SLOT_W]) +
                SLOT_W'(half_r >> 1);
  assign entry = {data_s_r[SYNC_STAGES-1], col_of(slot, half_r[0]),
                  slot[0], win_r, kind};

  always_comb begin
    st_nxt = st_r;
    half_nxt = half_r;
    win_nxt = win_r;
    line_nxt = line_r;
    calib_nxt = calib_r;
    done_nxt = 1'b0;
    err_nxt = err_r;
    ovf_nxt = ovf_r;
    push = 1'b0;
    kind = IRSQ_KIND_PIXEL;
    if (word_tick) begin
      case (code)
        FRAME_BEGIN_CODE: begin
          st_nxt = ST_LINE;
          half_nxt = '0;
          win_nxt = '0;
          line_nxt = '0;
          calib_nxt = 1'b1;
        end
        LINE_BEGIN_CODE: begin
          if (st_r != ST_IDLE) st_nxt = ST_LINE;
          half_nxt = '0;
        end
        LINE_FINISH_CODE: begin
          if (st_r == ST_LINE) begin
            st_nxt = ST_GAP;
            if (calib_r) begin
              calib_nxt = 1'b0;
            end else if (line_r == height - 1'b1) begin
              line_nxt = '0;
              win_nxt = win_r + 1'b1;
              if (win_r == window_count_m1) err_nxt = err_r;
            end else begin
              line_nxt = line_r + 1'b1;
            end
          end
        end
        FRAME_FINISH_CODE: begin
          // All configured windows must be complete at frame finish.
          if (st_r != ST_IDLE) begin
            st_nxt = ST_IDLE;
            done_nxt = 1'b1;
            if (win_r != window_count_m1 + 1'b1 || line_r != '0) begin
              err_nxt = 1'b1;
            end
          end
        end
        PIXEL_CODE, CALIB_CODE, REFERENCE_COLUMNS_CODE, CRC_CODE: begin
          if (st_r == ST_LINE) begin
            push = 1'b1;
            half_nxt = half_r + 1'b1;
            if (code == CALIB_CODE) kind = IRSQ_KIND_CALIB;
            else if (code == REFERENCE_COLUMNS_CODE) kind = IRSQ_KIND_REF;
            else if (code == CRC_CODE) kind = IRSQ_KIND_CRC;
            if (!fifo_ready) ovf_nxt = 1'b1;
          end
        end
        default: begin
          // Training pattern or idle words carry no pixels.
          push = 1'b0;
        end
      endcase
      // Wrapping past the fourth window also marks a window count mismatch, unless four windows are configured.
      if (win_nxt == '0 && win_r != '0 && win_r != window_count_m1 &&
          code == LINE_FINISH_CODE) begin
        err_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r <= ST_IDLE;
      half_r <= '0;
      win_r <= '0;
      line_r <= '0;
      calib_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      half_r <= half_nxt;
      win_r <= win_nxt;
      line_r <= line_nxt;
      calib_r <= calib_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      ovf_r <= ovf_nxt;
    end
  end
  assign in_frame = (st_r != ST_IDLE);
  assign frame_done = done_r;
  assign frame_error = err_r;
  assign overflow = ovf_r;

  // The link cannot be stalled, so a full FIFO drops the word and flags it.
  logic [ENTRY_W-1:0] head;
  irsq_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(FIFO_DEPTH_P)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(entry),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(head)
  );
  assign {pix_data, pix_col, pix_descending, pix_window, pix_kind} = head;
endmodule : irsq_host

// *** tb/irsq_host_sva.sv ***
// Assertion checker on the exposure pins and configuration outputs.
`timescale 1ns/1ps
module irsq_host_sva
  import irsq_pkg::*;
(
  input wire logic clk_sys, // Clock.
  input wire logic reset, // Reset.
  input wire logic slave_mode, // Mode.
  input wire logic expose_start, // Start pulse.
  input wire logic [TIMER_W-1:0] exposure_cycles, // Length.
  input wire logic [TIMER_W-1:0] second_stamp_cycles, // Stamp two.
  input wire logic [TIMER_W-1:0] third_stamp_cycles, // Stamp three.
  input wire logic second_stamp_en, // Enable two.
  input wire logic third_stamp_en, // Enable three.
  input wire logic [LANES-1:0] lane_fpn_request, // Request.
  input wire logic [LANES-1:0] output_lane_config_fpn, // Lane config.
  input wire logic sync_lane_config_fpn, // Sync config.
  input wire logic sequencer_config_three_calib, // Calibration enable.
  input wire logic exposure_pin, // Exposure.
  input wire logic second_reset_pin, // Reset two.
  input wire logic third_reset_pin, // Reset three.
  input wire logic frame_done, // Frame end pulse.
  input wire logic overflow // Lost word.
);
  logic [TIMER_W-1:0] expo_cnt_r;
  logic [TIMER_W-1:0] expo_cnt_nxt;
  // A counter lets stamp times of any size be checked without long delays.
  always_comb begin
    expo_cnt_nxt = exposure_pin ? expo_cnt_r + 1'b1 : '0;
  end
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset)
      expo_cnt_r <= '0;
    else
      expo_cnt_r <= expo_cnt_nxt;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_taken;
    expose_start && slave_mode && !exposure_pin && !$past(exposure_pin)
      && exposure_cycles != '0;
  endsequence
  property p_stamp(pin, en, stamp);
    pin |-> en && expo_cnt_r == stamp;
  endproperty
  chk_expo_rise: assert property (s_taken |=> exposure_pin)
    else $error("exposure pin did not rise");
  chk_expo_len: assert property ($fell(exposure_pin) |->
    expo_cnt_r == exposure_cycles) else $error("exposure length wrong");
  chk_second_when: assert property (p_stamp(second_reset_pin,
    second_stamp_en, second_stamp_cycles)) else $error("second reset wrong");
  chk_third_when: assert property (p_stamp(third_reset_pin,
    third_stamp_en, third_stamp_cycles)) else $error("third reset wrong");
  chk_stamp_pulse: assert property (second_reset_pin |=> !second_reset_pin)
    else $error("second reset pulse too long");
  chk_stamp_inside: assert property ((second_reset_pin || third_reset_pin)
    |-> exposure_pin) else $error("reset pulse outside exposure");
  chk_lane_copy: assert property (!$past(reset) |->
    output_lane_config_fpn == $past(lane_fpn_request))
    else $error("lane correction config wrong");
  chk_sync_fixed: assert property (sync_lane_config_fpn == 1'b0)
    else $error("sync lane correction enabled");
  chk_calib_fixed: assert property (sequencer_config_three_calib == 1'b1)
    else $error("calibration line disabled");
  chk_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("frame done longer than a cycle");
  chk_overflow_held: assert property (overflow |=> overflow)
    else $error("overflow flag cleared");
endmodule : irsq_host_sva
bind irsq_host irsq_host_sva chk_u (.clk_sys, .reset, .slave_mode,
  .expose_start, .exposure_cycles, .second_stamp_cycles, .third_stamp_cycles,
  .second_stamp_en, .third_stamp_en, .lane_fpn_request, .output_lane_config_fpn,
  .sync_lane_config_fpn, .sequencer_config_three_calib, .exposure_pin,
  .second_reset_pin, .third_reset_pin, .frame_done, .overflow);

// *** tb/irsq_dev_model.sv ***
// Behavioural sensor output: sync lane, data lanes and word clock.
`timescale 1ns/1ps
module irsq_dev_model
  import irsq_pkg::*;
(
  output logic link_clk, // Word clock, still between frames.
  output logic [WORD_W-1:0] sync_lane, // Protocol codes.
  output logic [LANE_BUS_W-1:0] data_lanes // Twelve lane words.
);
  int seq;
  initial begin
    link_clk = 1'b0;
    sync_lane = 10'h3a5;
    data_lanes = '0;
  end
  // Lanes change while the clock is low so they are steady at its rise.
  task automatic word(input logic [WORD_W-1:0] code, input bit dat);
    sync_lane = code;
    for (int k = 0; k < LANES; k++)
      data_lanes[k*WORD_W +: WORD_W] = dat ? WORD_W'(seq + k)
        : ~data_lanes[k*WORD_W +: WORD_W];
    seq += int'(dat);
    #40 link_clk = 1'b1;
    #40 link_clk = 1'b0;
  endtask : word
  task automatic frame(input int nwin, input int h[4], input int wd[4]);
    seq = 0;
    word(10'h2aa, 1'b0);
    word(FRAME_BEGIN_CODE, 1'b0);
    repeat (2 * SLOT_COUNT) word(CALIB_CODE, 1'b1);
    word(LINE_FINISH_CODE, 1'b0);
    for (int w = 0; w < nwin; w++) begin
      for (int l = 0; l < h[w]; l++) begin
        word(LINE_BEGIN_CODE, 1'b0);
        repeat (wd[w]) word(PIXEL_CODE, 1'b1);
        word(REFERENCE_COLUMNS_CODE, 1'b1);
        word(CRC_CODE, 1'b1);
        word(LINE_FINISH_CODE, 1'b0);
      end
    end
    word(FRAME_FINISH_CODE, 1'b0);
    // Released lanes show no stale value.
    sync_lane = ~sync_lane;
    data_lanes = ~data_lanes;
  endtask : frame
endmodule : irsq_dev_model

// *** tb/test_irsq_host.sv ***
// Self-checking bench for the image readout host controller.
`timescale 1ns/1ps
module test_irsq_host;
  import irsq_pkg::*;
  typedef struct {int m; int c; int w; int s;} irsq_exp_t;
  localparam int EXPO = 20;
  logic clk_sys = 1'b0, reset = 1'b1, slave_mode = 1'b1, expose_start = 1'b0;
  logic second_stamp_en = 1'b0, third_stamp_en = 1'b0, pix_ready = 1'b1;
  logic [TIMER_W-1:0] exposure_cycles = EXPO, second_stamp_cycles = 5;
  logic [TIMER_W-1:0] third_stamp_cycles = EXPO - 1;
  logic [WIN_W-1:0] window_count_m1 = '0;
  logic [WIN_MAX*LINE_W-1:0] window_heights = '0;
  logic [WIN_MAX*SLOT_W-1:0] window_x_start = '0;
  logic [LANES-1:0] lane_fpn_request = '0, output_lane_config_fpn;
  logic sync_lane_config_fpn, sequencer_config_three_calib, exposure_pin;
  logic second_reset_pin, third_reset_pin, link_clk, pix_valid;
  logic pix_descending, in_frame, frame_done, frame_error, overflow;
  logic [WORD_W-1:0] sync_lane;
  logic [LANE_BUS_W-1:0] data_lanes, pix_data;
  logic [COL_W-1:0] pix_col;
  logic [WIN_W-1:0] pix_window;
  logic [KIND_W-1:0] pix_kind;
  int miscompares = 0, checks = 0, cycles = 0, dones = 0, drained = 0, seq_x;
  int framed = 0;
  bit scoring = 1'b1;
  irsq_exp_t expq[$];
  irsq_exp_t e;
  irsq_host #(.FIFO_DEPTH_P(FIFO_DEPTH)) dut_u (.clk_sys, .reset,
    .slave_mode, .expose_start, .exposure_cycles, .second_stamp_cycles,
    .third_stamp_cycles, .second_stamp_en, .third_stamp_en, .window_count_m1,
    .window_heights, .window_x_start, .lane_fpn_request,
    .output_lane_config_fpn, .sync_lane_config_fpn,
    .sequencer_config_three_calib, .exposure_pin, .second_reset_pin,
    .third_reset_pin, .link_clk, .sync_lane, .data_lanes, .pix_valid,
    .pix_ready, .pix_data, .pix_col, .pix_descending, .pix_window, .pix_kind,
    .in_frame, .frame_done, .frame_error, .overflow);
  irsq_dev_model model_u (.link_clk, .sync_lane, .data_lanes);
  always #5 clk_sys = ~clk_sys;
  task automatic chk(input logic [LANE_BUS_W-1:0] got, exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: %s", $time, what);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  function automatic logic [LANE_BUS_W-1:0] lanes(input int s);
    for (int k = 0; k < LANES; k++)
      lanes[k*WORD_W +: WORD_W] = WORD_W'(s + k);
  endfunction : lanes
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // The user side stalls now and then while frames stream in.
  always @(negedge clk_sys) if (scoring) pix_ready = (cycles % 5 != 0);
  always @(posedge clk_sys) begin
    if (frame_done === 1'b1) dones++;
    if (in_frame === 1'b1) framed++;
    if (!reset && pix_valid === 1'b1 && pix_ready) begin
      if (!scoring) drained++;
      else if (expq.size() == 0) chk(1, 0, "unexpected entry");
      else begin
        e = expq.pop_front();
        chk(pix_kind, e.m, "kind");
        chk(pix_data, lanes(e.s), "lane words");
        if (e.m < 2) chk({pix_col, pix_descending}, e.c, "column");
        if (e.m == 0) chk(pix_window, e.w, "window");
      end
    end
  end
  task automatic expect_line(input int m, input int w, input int xs, int n);
    int s;
    int c;
    for (int i = 0; i < n; i++) begin
      s = xs + i / 2;
      c = (s % 2) ? 24 * s + 23 - i % 2 : 24 * s + i % 2;
      expq.push_back('{m, 2 * c + s % 2, w, seq_x});
      seq_x++;
    end
  endtask : expect_line
  task automatic t_config;
    lane_fpn_request = 12'ha5c;
    repeat (2) @(negedge clk_sys);
    chk(output_lane_config_fpn, 12'ha5c, "lane correction");
    chk(sync_lane_config_fpn, 0, "sync lane correction");
    chk(sequencer_config_three_calib, 1, "calibration line");
  endtask : t_config
  task automatic t_expose(input bit slv, input bit e2, input bit e3);
    int n, p2, p3;
    @(negedge clk_sys);
    slave_mode = slv;
    second_stamp_en = e2;
    third_stamp_en = e3;
    {n, p2, p3} = '0;
    expose_start = 1'b1;
    for (int k = 0; k < EXPO + 4; k++) begin
      @(negedge clk_sys);
      expose_start = (k == 3);
      n += exposure_pin;
      p2 += second_reset_pin;
      p3 += third_reset_pin;
    end
    chk(n, slv ? EXPO : 0, "exposure length");
    chk(p2, slv & e2, "second reset count");
    chk(p3, slv & e3, "third reset count");
  endtask : t_expose
  task automatic t_frame(input int nwin, input int h[4], input int wd[4],
    input int xs[4], input int short);
    int d0, f0;
    seq_x = 0;
    for (int w = 0; w < WIN_MAX; w++) begin
      window_heights[w*LINE_W +: LINE_W] = LINE_W'(h[w] + short);
      window_x_start[w*SLOT_W +: SLOT_W] = SLOT_W'(xs[w]);
    end
    window_count_m1 = WIN_W'(nwin - 1);
    expect_line(1, 0, 0, 2 * SLOT_COUNT);
    for (int w = 0; w < nwin; w++)
      for (int l = 0; l < h[w]; l++) begin
        expect_line(0, w, xs[w], wd[w]);
        expect_line(2, w, 0, 1);
        expect_line(3, w, 0, 1);
      end
    @(negedge clk_sys);
    d0 = dones;
    f0 = framed;
    model_u.frame(nwin, h, wd);
    repeat (40) @(negedge clk_sys);
    chk(dones - d0, 1, "frame done pulses");
    chk(framed > f0, 1, "in frame while streaming");
    chk(frame_error, short != 0, "frame error");
    chk(in_frame, 0, "in frame after finish");
    if (scoring) chk(expq.size(), 0, "entries missing");
  endtask : t_frame
  initial begin
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    t_config();
    for (int i = 0; i < 5; i++) t_expose(i != 4, i[0], i[1]);
    t_frame(2, '{2, 1, 0, 0}, '{4, 3, 0, 0}, '{3, 0, 0, 0}, 0);
    t_frame(4, '{1, 1, 1, 1}, '{2, 3, 2, 2}, '{0, 1, 52, 53}, 0);
    scoring = 1'b0;
    @(negedge clk_sys);
    pix_ready = 1'b0;
    t_frame(1, '{1, 0, 0, 0}, '{4, 0, 0, 0}, '{0, 0, 0, 0}, 1);
    chk(overflow, 1, "overflow on full buffer");
    chk(pix_valid, 1, "full buffer valid");
    pix_ready = 1'b1;
    repeat (20) @(negedge clk_sys);
    chk(drained, FIFO_DEPTH, "buffer depth");
    chk(pix_valid, 0, "buffer empty");
    give_verdict();
  end
endmodule : test_irsq_host
